// ### common/can_bit_timing_cfg.svh
// register offsets, field positions and reset values of the bit timing block
`ifndef CAN_BIT_TIMING_CFG_SVH
`define CAN_BIT_TIMING_CFG_SVH

// register byte offsets
`define OFS_BIT_TIMING   8'h00
`define OFS_CONTROL      8'h04
`define OFS_STATUS       8'h08

// bit_timing_register field positions (all fields hold functional value minus one)
`define FLD_PRESCALER_LSB 0
`define FLD_PROP_LSB      8
`define FLD_PHASE1_LSB    12
`define FLD_PHASE2_LSB    16
`define FLD_JUMP_LSB      20

// control register bit positions
`define FLD_ENABLE_BIT    0
`define FLD_HARD_ARM_BIT  1

// reset values of the timing fields
`define RST_PRESCALER     5'h00
`define RST_PROP          3'h1
`define RST_PHASE1        3'h2
`define RST_PHASE2        3'h2
`define RST_JUMP          2'h0

// axi response codes
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// ### common/can_bit_timing_pkg.sv
// types shared by the bit timing block and its bench
package can_bit_timing_pkg;

	// axi4-lite signals driven by the master
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} axi_req_type;

	// axi4-lite signals driven by the slave
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_rsp_type;

	// programmed timing fields, each one less than its functional value
	typedef struct packed {
		logic [4:0] quantum_prescaler_value;
		logic [2:0] prop_seg;
		logic [2:0] phase_buffer_one;
		logic [2:0] phase_buffer_two;
		logic [1:0] resync_jump_width;
	} timing_type;

	// position inside the bit time
	typedef enum logic [1:0] {
		SEG_SYNC,
		SEG_BEFORE,
		SEG_AFTER
	} seg_type;

endpackage

// ### src/rx_synchronizer.sv
// two-stage synchroniser for the bus receive pin
`timescale 1ns/1ps
`default_nettype none

module rx_synchronizer (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic pin,
	output var  logic level
);
	// both stages in one state word
	typedef struct packed {
		logic meta;   // first stage, read only by the second
		logic stable; // second stage
	} sync_state_type;

	sync_state_type s_r;
	sync_state_type s_nxt;

	// shift the pin through both stages; idle bus is recessive
	always_comb begin
		s_nxt        = s_r;
		s_nxt.meta   = pin;
		s_nxt.stable = s_r.meta;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_r <= '{meta: 1'b1, stable: 1'b1};
		end else begin
			s_r <= s_nxt;
		end
	end

	assign level = s_r.stable;
endmodule

`default_nettype wire

// ### src/quantum_prescaler.sv
// time quantum generator: one tick every prescaler+1 clocks
`timescale 1ns/1ps
`default_nettype none

module quantum_prescaler #(
	parameter int WIDTH = 5
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic             run,
	input  wire logic [WIDTH-1:0] divide_m1,
	output var  logic             tick
);
	typedef struct packed {
		logic [WIDTH-1:0] cnt;  // clocks elapsed in this quantum
		logic             tick; // registered quantum strobe
	} pre_state_type;

	pre_state_type s_r;
	pre_state_type s_nxt;

	// count clocks; wrap and strobe when the programmed length is reached
	always_comb begin
		s_nxt      = s_r;
		s_nxt.tick = 1'b0;
		if (!run) begin
			s_nxt.cnt = '0;
		end else if (s_r.cnt >= divide_m1) begin
			s_nxt.cnt  = '0;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;
endmodule

`default_nettype wire

// ### src/can_bit_timing_sync.sv
// can bit timing logic: quanta, segments, sample point and synchronisation
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "can_bit_timing_cfg.svh"

module can_bit_timing_sync (
	input  wire logic                             REF_CLK,
	input  wire logic                             SRST,
	input  wire logic                             CAN_RX,
	input  wire can_bit_timing_pkg::axi_req_type  AXI_REQ,
	output var  can_bit_timing_pkg::axi_rsp_type  AXI_RSP,
	output var  logic                             SAMPLE_STROBE,
	output var  logic                             RX_BIT,
	output var  logic                             SYNC_STROBE
);
	import can_bit_timing_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		axi_rsp_type rsp;          // registered bus answer
		logic        aw_have;      // write address held
		logic [7:0]  aw_addr;      // held write address
		logic        w_have;       // write data held
		logic [31:0] w_data;       // held write data
		logic [3:0]  w_strb;       // held byte strobes
		timing_type  timing;       // programmed timing fields
		logic        enable;       // bit timing running
		logic        hard_arm;     // next edge is a frame start
		seg_type     seg;          // current segment
		logic [4:0]  qcnt;         // quantum index inside the segment
		logic [2:0]  lengthen;     // extra quanta of buffer one this bit
		logic [2:0]  shorten;      // quanta removed from buffer two this bit
		logic        sync_done;    // a sync happened since last sample point
		logic        prev_sample;  // level at previous sample point
		logic        rx_bit;       // sampled bit value
		logic        sample_pulse; // one clock at each sample point
		logic        sync_pulse;   // one clock at each synchronisation
		logic [7:0]  sample_cnt;   // free-running count of sample points
	} top_state_type;

	top_state_type s_r;   // registered state
	top_state_type s_nxt; // next state

	logic       rx_level;   // synchronised bus level, 1 is recessive
	logic       qtick;      // one clock per time quantum
	logic [3:0] segment_before_sample_m1;   // segment before sample, programmed form
	logic [3:0] jump_len;   // effective jump width in quanta
	logic [4:0] err_mag;    // magnitude of the edge phase error
	logic [4:0] adj;        // applied correction
	logic       candidate;  // qualifying edge this quantum
	logic [31:0] rd_word;   // read mux output
	logic        rd_ok;     // read address decoded
	logic        wr_ok;     // write address decoded
	logic [31:0] wr_word;   // held write data, unstrobed bytes cleared

	////////////////////////////////////////////////////////////////////////////////
	// helpers

	// smaller of two quanta counts
	function automatic logic [4:0] min5(input logic [4:0] a, input logic [4:0] b);
		min5 = (a < b) ? a : b;
	endfunction

	// merge written bytes into an old word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
		input logic [3:0] strb);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				merge[i*8 +: 8] = val[i*8 +: 8];
			end
		end
	endfunction

	// register address decode, used by reads and writes
	function automatic logic mapped(input logic [7:0] a, input logic writable);
		mapped = (a == `OFS_BIT_TIMING) || (a == `OFS_CONTROL) || (!writable && (a == `OFS_STATUS));
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// submodules

	// pin crosses two flip-flops before use
	rx_synchronizer u_rx (
		.clk   (REF_CLK),
		.srst  (SRST),
		.pin   (CAN_RX),
		.level (rx_level)
	);

	// quantum strobe from the programmed prescaler
	quantum_prescaler #(
		.WIDTH (5)
	) u_pre (
		.clk       (REF_CLK),
		.srst      (SRST),
		.run       (s_r.enable),
		.divide_m1 (s_r.timing.quantum_prescaler_value),
		.tick      (qtick)
	);

	////////////////////////////////////////////////////////////////////////////////
	// derived timing values

	// segment before sample joins propagation and buffer one
	always_comb begin
		segment_before_sample_m1 = 4'({1'b0, s_r.timing.prop_seg} + {1'b0, s_r.timing.phase_buffer_one} + 4'h1);
		// jump width limited to the shorter buffer so the counters cannot wrap
		jump_len = {2'b00, s_r.timing.resync_jump_width} + 4'h1;
		if (jump_len > {1'b0, s_r.timing.phase_buffer_one} + 4'h1) begin
			jump_len = {1'b0, s_r.timing.phase_buffer_one} + 4'h1;
		end
		if (jump_len > {1'b0, s_r.timing.phase_buffer_two} + 4'h1) begin
			jump_len = {1'b0, s_r.timing.phase_buffer_two} + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read mux

	// held write word; fields of unstrobed bytes are restored in the write path
	assign wr_word = merge(32'h0000_0000, s_r.w_data, s_r.w_strb);

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_ok   = mapped(AXI_REQ.araddr, 1'b0);
		wr_ok   = mapped(s_r.aw_addr, 1'b1);
		case (AXI_REQ.araddr)
			`OFS_BIT_TIMING: begin
				rd_word[`FLD_PRESCALER_LSB +: 5] = s_r.timing.quantum_prescaler_value;
				rd_word[`FLD_PROP_LSB +: 3]      = s_r.timing.prop_seg;
				rd_word[`FLD_PHASE1_LSB +: 3]    = s_r.timing.phase_buffer_one;
				rd_word[`FLD_PHASE2_LSB +: 3]    = s_r.timing.phase_buffer_two;
				rd_word[`FLD_JUMP_LSB +: 2]      = s_r.timing.resync_jump_width;
			end
			`OFS_CONTROL: begin
				rd_word[`FLD_ENABLE_BIT]   = s_r.enable;
				rd_word[`FLD_HARD_ARM_BIT] = s_r.hard_arm;
			end
			`OFS_STATUS: begin
				// block state visible to software
				rd_word[0]    = s_r.rx_bit;
				rd_word[1]    = s_r.sync_done;
				rd_word[3:2]  = s_r.seg;
				rd_word[4]    = s_r.hard_arm;
				rd_word[15:8] = s_r.sample_cnt;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// next state: bit timing first, then bus so software writes win

	always_comb begin
		s_nxt              = s_r;
		s_nxt.sample_pulse = 1'b0;
		s_nxt.sync_pulse   = 1'b0;
		err_mag            = 5'h00;
		adj                = 5'h00;
		// only a falling bus after a recessive sample qualifies
		candidate = s_r.enable && s_r.prev_sample && !rx_level && !s_r.sync_done;

		if (!s_r.enable) begin
			// stopped: park at the sync slot with a recessive history
			s_nxt.seg         = SEG_SYNC;
			s_nxt.qcnt        = 5'h00;
			s_nxt.lengthen    = 3'h0;
			s_nxt.shorten     = 3'h0;
			s_nxt.sync_done   = 1'b0;
			s_nxt.prev_sample = 1'b1;
		end else if (qtick) begin
			if (candidate && s_r.hard_arm) begin
				// frame start: this quantum becomes the sync slot
				s_nxt.seg        = SEG_BEFORE;
				s_nxt.qcnt       = 5'h00;
				s_nxt.lengthen   = 3'h0;
				s_nxt.shorten    = 3'h0;
				s_nxt.sync_done  = 1'b1;
				s_nxt.sync_pulse = 1'b1;
				s_nxt.hard_arm   = 1'b0;
			end else begin
				case (s_r.seg)
					SEG_SYNC: begin
						// sync slot is always one quantum; an edge here has zero error
						if (candidate) begin
							s_nxt.sync_done  = 1'b1;
							s_nxt.sync_pulse = 1'b1;
						end
						s_nxt.seg  = SEG_BEFORE;
						s_nxt.qcnt = 5'h00;
					end
					SEG_BEFORE: begin
						// late edge: error counts quanta after the sync slot
						if (candidate) begin
							err_mag          = s_r.qcnt + 5'h01;
							adj              = min5(err_mag, {1'b0, jump_len});
							s_nxt.lengthen   = adj[2:0];
							s_nxt.sync_done  = 1'b1;
							s_nxt.sync_pulse = 1'b1;
						end
						if (s_r.qcnt >= {1'b0, segment_before_sample_m1} + {2'b00, s_nxt.lengthen}) begin
							// sample point: one sample, at the adjusted end of buffer one
							s_nxt.rx_bit       = rx_level;
							s_nxt.prev_sample  = rx_level;
							s_nxt.sample_pulse = 1'b1;
							s_nxt.sample_cnt   = s_r.sample_cnt + 8'h01;
							s_nxt.sync_done    = 1'b0;
							s_nxt.lengthen     = 3'h0;
							s_nxt.seg          = SEG_AFTER;
							s_nxt.qcnt         = 5'h00;
						end else begin
							s_nxt.qcnt = s_r.qcnt + 5'h01;
						end
					end
					SEG_AFTER: begin
						if (candidate) begin
							// early edge: error counts quanta left before the next sync slot
							err_mag          = {2'b00, s_r.timing.phase_buffer_two} + 5'h01 - s_r.qcnt;
							s_nxt.sync_done  = 1'b1;
							s_nxt.sync_pulse = 1'b1;
						end
						if (candidate && err_mag <= {1'b0, jump_len}) begin
							// fully compensated: end the bit now and omit the sync slot
							s_nxt.seg     = SEG_BEFORE;
							s_nxt.qcnt    = 5'h00;
							s_nxt.shorten = 3'h0;
						end else begin
							if (candidate) begin
								// only the jump width is removed; the rest stays as error
								s_nxt.shorten = jump_len[2:0];
							end
							if (s_r.qcnt + {2'b00, s_nxt.shorten} >= {2'b00, s_r.timing.phase_buffer_two}) begin
								s_nxt.seg     = SEG_SYNC;
								s_nxt.qcnt    = 5'h00;
								s_nxt.shorten = 3'h0;
							end else begin
								s_nxt.qcnt = s_r.qcnt + 5'h01;
							end
						end
					end
					default: begin
						s_nxt.seg  = SEG_SYNC;
						s_nxt.qcnt = 5'h00;
					end
				endcase
			end
		end

		// write channel: address and data accepted in either order
		if (AXI_REQ.awvalid && s_r.rsp.awready) begin
			s_nxt.aw_have = 1'b1;
			s_nxt.aw_addr = AXI_REQ.awaddr;
		end
		if (AXI_REQ.wvalid && s_r.rsp.wready) begin
			s_nxt.w_have = 1'b1;
			s_nxt.w_data = AXI_REQ.wdata;
			s_nxt.w_strb = AXI_REQ.wstrb;
		end
		if (s_r.rsp.bvalid && AXI_REQ.bready) begin
			s_nxt.rsp.bvalid = 1'b0;
		end
		if (s_r.aw_have && s_r.w_have && !s_r.rsp.bvalid) begin
			// both halves present: perform the write and answer
			s_nxt.aw_have    = 1'b0;
			s_nxt.w_have     = 1'b0;
			s_nxt.rsp.bvalid = 1'b1;
			s_nxt.rsp.bresp  = wr_ok ? `RESP_OKAY : `RESP_SLVERR;
			if (s_r.aw_addr == `OFS_BIT_TIMING) begin
				// fields are kept in their programmed form
				s_nxt.timing.quantum_prescaler_value = wr_word[`FLD_PRESCALER_LSB +: 5];
				s_nxt.timing.prop_seg          = wr_word[`FLD_PROP_LSB +: 3];
				s_nxt.timing.phase_buffer_one  = wr_word[`FLD_PHASE1_LSB +: 3];
				s_nxt.timing.phase_buffer_two  = wr_word[`FLD_PHASE2_LSB +: 3];
				s_nxt.timing.resync_jump_width = wr_word[`FLD_JUMP_LSB +: 2];
				if (!s_r.w_strb[0]) begin
					s_nxt.timing.quantum_prescaler_value = s_r.timing.quantum_prescaler_value;
				end
				if (!s_r.w_strb[1]) begin
					s_nxt.timing.prop_seg         = s_r.timing.prop_seg;
					s_nxt.timing.phase_buffer_one = s_r.timing.phase_buffer_one;
				end
				if (!s_r.w_strb[2]) begin
					s_nxt.timing.phase_buffer_two  = s_r.timing.phase_buffer_two;
					s_nxt.timing.resync_jump_width = s_r.timing.resync_jump_width;
				end
			end else if (s_r.aw_addr == `OFS_CONTROL && s_r.w_strb[0]) begin
				// a written one arms the hard sync even in the cycle it fires
				s_nxt.enable = s_r.w_data[`FLD_ENABLE_BIT];
				if (s_r.w_data[`FLD_HARD_ARM_BIT]) begin
					s_nxt.hard_arm = 1'b1;
				end
			end
		end

		// read channel: answer one clock after the address is taken
		if (s_r.rsp.rvalid && AXI_REQ.rready) begin
			s_nxt.rsp.rvalid = 1'b0;
		end
		if (AXI_REQ.arvalid && s_r.rsp.arready) begin
			s_nxt.rsp.rvalid = 1'b1;
			s_nxt.rsp.rdata  = rd_word;
			s_nxt.rsp.rresp  = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
		end

		// ready flags registered from the next state
		s_nxt.rsp.awready = !s_nxt.aw_have && !s_nxt.rsp.bvalid;
		s_nxt.rsp.wready  = !s_nxt.w_have && !s_nxt.rsp.bvalid;
		s_nxt.rsp.arready = !s_nxt.rsp.rvalid;
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			s_r                                 <= '0;
			s_r.timing.quantum_prescaler_value  <= `RST_PRESCALER;
			s_r.timing.prop_seg                 <= `RST_PROP;
			s_r.timing.phase_buffer_one         <= `RST_PHASE1;
			s_r.timing.phase_buffer_two         <= `RST_PHASE2;
			s_r.timing.resync_jump_width        <= `RST_JUMP;
			s_r.seg                             <= SEG_SYNC;
			s_r.prev_sample                     <= 1'b1;
			s_r.rx_bit                          <= 1'b1;
			s_r.rsp.awready                     <= 1'b1;
			s_r.rsp.wready                      <= 1'b1;
			s_r.rsp.arready                     <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// outputs straight from the state register
	assign AXI_RSP       = s_r.rsp;
	assign SAMPLE_STROBE = s_r.sample_pulse;
	assign RX_BIT        = s_r.rx_bit;
	assign SYNC_STROBE   = s_r.sync_pulse;
endmodule

`default_nettype wire

// ### verif/can_bit_timing_checker.sv
// port-level assertions for the bit timing block
`timescale 1ns/1ps
`default_nettype none

module can_bit_timing_checker (
	input wire logic                            REF_CLK,
	input wire logic                            SRST,
	input wire logic                            CAN_RX,
	input wire can_bit_timing_pkg::axi_req_type AXI_REQ,
	input wire can_bit_timing_pkg::axi_rsp_type AXI_RSP,
	input wire logic                            SAMPLE_STROBE,
	input wire logic                            RX_BIT,
	input wire logic                            SYNC_STROBE
);
	import can_bit_timing_pkg::*;

	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);

	logic synced_r;   // a sync was taken since the last sample point
	logic synced_nxt; // next value of the flag

	////////////////////////////////////////////////////////////////
	// sample point clears the flag, a sync sets it
	always_comb begin
		synced_nxt = synced_r;
		if (SAMPLE_STROBE) begin
			synced_nxt = 1'b0;
		end else if (SYNC_STROBE) begin
			synced_nxt = 1'b1;
		end
	end

	// register the flag
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			synced_r <= 1'b0;
		end else begin
			synced_r <= synced_nxt;
		end
	end

	////////////////////////////////////////////////////////////////
	sync_once_a: assert property (SYNC_STROBE |-> !synced_r)
		else $error("second sync before the sample point");
	sync_recessive_a: assert property (SYNC_STROBE |-> RX_BIT)
		else $error("sync after a dominant sample");
	rx_hold_a: assert property ($changed(RX_BIT) |-> SAMPLE_STROBE || $past(SAMPLE_STROBE))
		else $error("received bit moved off the sample point");
	sample_pulse_a: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE)
		else $error("sample pulse longer than one clock");
	sync_apart_a: assert property (SYNC_STROBE |-> !SAMPLE_STROBE)
		else $error("sample taken on the sync quantum");
	sync_sample_a: assert property (SYNC_STROBE |-> ##[1:1000] SAMPLE_STROBE)
		else $error("no sample point after a sync");
	write_resp_a: assert property (AXI_REQ.awvalid && AXI_RSP.awready && AXI_REQ.wvalid && AXI_RSP.wready
		|-> ##2 AXI_RSP.bvalid) else $error("write answer late");
	read_resp_a: assert property (AXI_REQ.arvalid && AXI_RSP.arready |=> AXI_RSP.rvalid)
		else $error("read answer late");
	resp_drop_a: assert property (AXI_RSP.bvalid && AXI_REQ.bready |=> !AXI_RSP.bvalid)
		else $error("write answer not released");
	ready_low_a: assert property (AXI_RSP.bvalid |-> !AXI_RSP.awready && !AXI_RSP.wready)
		else $error("write ready during answer");

	// main scenarios
	edge_c: cover property ($fell(CAN_RX));
	sync_c: cover property (SYNC_STROBE);
	werr_c: cover property (AXI_RSP.bvalid && AXI_RSP.bresp == 2'h2);
	rerr_c: cover property (AXI_RSP.rvalid && AXI_RSP.rresp == 2'h2);
endmodule

`default_nettype wire

// ### verif/can_node_model.sv
// far node that sends a short bit pattern onto the receive line
`timescale 1ns/1ps
`default_nettype none

module can_node_model (
	input  wire logic clk,
	output var  logic tx
);
	// idle bus reads recessive through the transceiver
	initial tx = 1'b1;

	////////////////////////////////////////////////////////////////
	// msb first, each bit held for period clocks of the node's oscillator
	task automatic send(input logic [7:0] bits, input int period);
		for (int i = 7; i >= 0; i--) begin
			tx <= bits[i];
			repeat (period) @(posedge clk);
		end
		tx <= 1'b1;
	endtask
endmodule

`default_nettype wire

// ### verif/tb_top.sv
// self-checking bench for the bit timing block
`timescale 1ns/1ps
`default_nettype none
`include "can_bit_timing_cfg.svh"

module tb_top;
	import can_bit_timing_pkg::*;

	logic        ref_clk;    // 20 MHz clock
	logic        srst;       // synchronous reset
	logic        can_rx;     // bus level from the node
	axi_req_type req;        // register bus requests
	axi_rsp_type rsp;        // register bus answers
	logic        smp;        // sample point pulse
	logic        rxb;        // last sampled bit
	logic        syn;        // sync pulse
	int          fail_count; // mismatches
	int          n_tests;    // comparisons
	int          k;          // clocks since last sample
	int          expn;       // expected clocks to next sample
	int          qc;         // clocks per quantum
	int          nq;         // nominal quanta per bit
	int          prop;       // propagation quanta
	int          ph1;        // phase buffer one quanta
	int          ph2;        // phase buffer two quanta
	int          jw;         // jump width quanta
	bit          have;       // previous sample known
	bit          en;         // timing enabled
	bit          hard_exp;   // next sync is the hard one
	bit          cap;        // capturing frame bits
	bit          pend;       // take the bit now
	logic        got[$];     // captured bits
	int          cfg[4][5] = '{'{1, 2, 3, 3, 1}, '{4, 2, 3, 3, 1}, '{32, 1, 1, 1, 1}, '{1, 8, 8, 8, 4}};

	can_bit_timing_sync uut (.REF_CLK(ref_clk), .SRST(srst), .CAN_RX(can_rx), .AXI_REQ(req),
		.AXI_RSP(rsp), .SAMPLE_STROBE(smp), .RX_BIT(rxb), .SYNC_STROBE(syn));
	can_node_model node (.clk(ref_clk), .tx(can_rx));

	// free-running clock
	always #25 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////
	// compare and count
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %0t got %h expected %h", $time, g, e);
		end
	endtask

	// verdict and end of run
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// register write, both channels offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge ref_clk);
		req.awvalid <= 1'b1;
		req.awaddr  <= a;
		req.wvalid  <= 1'b1;
		req.wdata   <= v;
		req.wstrb   <= 4'hf;
		req.bready  <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
			if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
			if (rsp.bvalid) begin
				req.bready <= 1'b0;
				chk({30'h0, rsp.bresp}, {30'h0, er});
				break;
			end
		end
	endtask

	// register read, masked compare
	task automatic rd(input logic [7:0] a, input logic [31:0] ev, input logic [31:0] m, input logic [1:0] er);
		@(posedge ref_clk);
		req.arvalid <= 1'b1;
		req.araddr  <= a;
		req.rready  <= 1'b1;
		forever begin
			@(posedge ref_clk);
			if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
			if (rsp.rvalid) begin
				req.rready <= 1'b0;
				chk(rsp.rdata & m, ev);
				chk({30'h0, rsp.rresp}, {30'h0, er});
				break;
			end
		end
	endtask

	// wait for n sample points
	task automatic wait_smp(input int n);
		repeat (n) @(posedge ref_clk iff smp);
	endtask

	// program timing in functional units and run
	task automatic setup(input int p, input int a, input int b, input int c, input int j);
		logic [31:0] v;
		qc = p;
		prop = a;
		ph1 = b;
		ph2 = c;
		jw = j;
		nq = 1 + a + b + c;
		v = 32'((p - 1) << `FLD_PRESCALER_LSB | (a - 1) << `FLD_PROP_LSB | (b - 1) << `FLD_PHASE1_LSB
			| (c - 1) << `FLD_PHASE2_LSB | (j - 1) << `FLD_JUMP_LSB);
		en = 1'b0;
		wr(`OFS_CONTROL, 32'h0000_0000, `RESP_OKAY);
		wr(`OFS_BIT_TIMING, v, `RESP_OKAY);
		rd(`OFS_BIT_TIMING, v, 32'hFFFF_FFFF, `RESP_OKAY);
		wr(`OFS_CONTROL, 32'h0000_0001, `RESP_OKAY);
		en = 1'b1;
	endtask

	// next sample distance after a resync at clock pos of the bit
	function automatic int after_sync(input int pos);
		if (pos <= ph2) return nq - ((ph2 + 1 - pos < jw) ? ph2 + 1 - pos : jw);
		if (pos == ph2 + 1) return nq;
		return nq + ((pos - ph2 - 1 < jw) ? pos - ph2 - 1 : jw);
	endfunction

	// armed frame from the node with a chosen oscillator period
	task automatic frame(input int period, input int j, input bit check_bits);
		logic [7:0] pat;
		pat = 8'h53;
		setup(1, 2, 3, 3, j);
		wait_smp(2);
		hard_exp = 1'b1;
		wr(`OFS_CONTROL, 32'h0000_0003, `RESP_OKAY);
		wait_smp(1);
		node.send(pat, period);
		wait_smp(3);
		rd(`OFS_STATUS, 32'h0000_0001, 32'h0000_0013, `RESP_OKAY);
		if (check_bits) begin
			for (int i = 0; i < 8; i++) chk({31'h0, got[i]}, {31'h0, pat[7 - i]});
		end
	endtask

	////////////////////////////////////////////////////////////////
	// sample point spacing and captured bits
	always @(negedge ref_clk) begin
		k++;
		if (pend) begin
			got.push_back(rxb);
			cap = (got.size() < 8);
		end
		pend = 1'b0;
		if (srst || !en) begin
			have = 1'b0;
		end else if (syn && hard_exp) begin
			expn = k + (prop + ph1) * qc;
			hard_exp = 1'b0;
			cap = 1'b1;
			got.delete();
		end else if (syn) begin
			expn = after_sync(k);
		end else if (smp) begin
			if (have) chk(32'(k), 32'(expn));
			expn = nq * qc;
			k = 0;
			have = 1'b1;
			pend = cap;
		end
	end

	// watchdog
	initial begin
		#1_000_000;
		fail_count++;
		$display("BAD %0t watchdog expired", $time);
		finish_test();
	end

	// main sequence
	initial begin
		ref_clk = 1'b0;
		srst = 1'b1;
		req = '0;
		repeat (4) @(posedge ref_clk);
		srst <= 1'b0;
		rd(`OFS_BIT_TIMING, 32'h0002_2100, 32'hFFFF_FFFF, `RESP_OKAY);
		rd(`OFS_CONTROL, 32'h0000_0000, 32'hFFFF_FFFF, `RESP_OKAY);
		rd(8'h0C, 32'h0000_0000, 32'hFFFF_FFFF, `RESP_SLVERR);
		wr(8'h0C, 32'hFFFF_FFFF, `RESP_SLVERR);
		wr(`OFS_STATUS, 32'hFFFF_FFFF, `RESP_SLVERR);
		rd(`OFS_BIT_TIMING, 32'h0002_2100, 32'hFFFF_FFFF, `RESP_OKAY);
		foreach (cfg[i]) begin
			setup(cfg[i][0], cfg[i][1], cfg[i][2], cfg[i][3], cfg[i][4]);
			wait_smp(4);
		end
		frame(9, 1, 1);
		frame(10, 2, 1);
		frame(8, 1, 0);
		finish_test();
	end
endmodule

bind can_bit_timing_sync can_bit_timing_checker chk_i (.REF_CLK(REF_CLK), .SRST(SRST), .CAN_RX(CAN_RX),
	.AXI_REQ(AXI_REQ), .AXI_RSP(AXI_RSP), .SAMPLE_STROBE(SAMPLE_STROBE), .RX_BIT(RX_BIT),
	.SYNC_STROBE(SYNC_STROBE));

`default_nettype wire
